// [rtl/usbp_pkg.sv]
// Purpose: Shared constants for the pipe response control block
// Assumes: 32-bit APB data, one word per register
// Notes: Offsets are byte addresses
`default_nettype none
package usbp_pkg;
   // ***********************************************
   // Sizes
   // ***********************************************
   localparam int NUM_PIPES = 10;
   localparam int MPS_W = 11;
   localparam int PIPE_W = 4;
   // ***********************************************
   // Register map
   // ***********************************************
   localparam logic [7:0] CTRL_BASE = 8'h00;
   localparam logic [7:0] CFG_BASE = 8'h40;
   localparam logic [7:0] MODE_ADDR = 8'h80;
   localparam logic [7:0] REQ_LO_ADDR = 8'h84;
   localparam logic [7:0] REQ_HI_ADDR = 8'h88;
   // Control word fields
   localparam int CTRL_PID_LSB = 0;
   localparam int CTRL_FORCE0_BIT = 5;
   localparam int CTRL_FORCE1_BIT = 6;
   localparam int CTRL_MON_BIT = 7;
   localparam int CTRL_ACTIVE_BIT = 8;
   // Config word fields
   localparam int CFG_TYPE_LSB = 0;
   localparam int CFG_DIR_BIT = 2;
   localparam int CFG_SHORT_BIT = 3;
   localparam int CFG_MPS_LSB = 16;
   // Reset values
   localparam logic [MPS_W-1:0] MPS_RESET = 11'h040;
   localparam logic HOST_MODE_RESET = 1'b0;
   // ***********************************************
   // Encodings
   // ***********************************************
   localparam logic [1:0] PID_NAK = 2'h0;
   localparam logic [1:0] PID_BUF = 2'h1;
   localparam logic [1:0] PID_STALL = 2'h2;
   localparam logic [1:0] TYPE_CTRL = 2'h0;
   localparam logic [1:0] TYPE_BULK = 2'h1;
   localparam logic [1:0] TYPE_INTR = 2'h2;
   localparam logic [1:0] TYPE_ISO = 2'h3;
   localparam logic [1:0] HS_ACK = 2'h0;
   localparam logic [1:0] HS_NAK = 2'h1;
   localparam logic [1:0] HS_STALL = 2'h2;
   localparam logic [1:0] HS_DATA = 2'h3;
   // Link events reported by the serial engine
   localparam logic [3:0] EV_DATA_ACKED = 4'h1;
   localparam logic [3:0] EV_RX_OK = 4'h2;
   localparam logic [3:0] EV_RX_ERR = 4'h3;
   localparam logic [3:0] EV_NO_RESP = 4'h4;
   localparam logic [3:0] EV_STALL_RX = 4'h5;
   localparam logic [3:0] EV_TRN_DONE = 4'h6;
   localparam logic [3:0] EV_SETUP_OK = 4'h7;
   localparam logic [3:0] EV_SEQ_ERR = 4'h8;
   localparam logic [3:0] EV_STATUS_STAGE = 4'h9;
   localparam logic [1:0] ERR_LIMIT = 2'h3;
endpackage : usbp_pkg
`default_nettype wire

// [rtl/usbp_pipe_ctrl.sv]
// Purpose: Per-pipe response setting, forced NAK/STALL, data toggle, APB registers
// Assumes: Serial engine reports link events and buffer status synchronously
// Notes: Pipe 0 is the default control pipe
`default_nettype none
// What this block does
// [RULE_01] Pipes 6-9 limited to 64-byte packets; not enforced, every pipe takes any 11-bit MPS
// [RULE_02] Control pipe size 64 HS, 8-64 FS; not checked, any 11-bit MPS is stored
// [RULE_03] Bulk pipes 512 HS, 8-64 FS; not checked, any 11-bit MPS is stored
// [RULE_04] Isochronous size 1-1024 HS, 1-1023 FS; not checked, any 11-bit MPS is stored
// [RULE_05] Host: NAK or STALL pipe issues nothing
// [RULE_06] Host: tokens follow buffer data or space
// [RULE_07] Peripheral: answer NAK or STALL as set
// [RULE_08] Peripheral: allowed setting answers by buffer
// [RULE_09] Setup always ACKed and request stored
// [RULE_10] Three receive errors force NAK
// [RULE_11] Host short packet or count forces NAK
// [RULE_12] Host STALL received or overrun forces STALL
// [RULE_13] Peripheral setup, short, count force NAK
// [RULE_14] Peripheral overrun or sequence error STALL
// [RULE_15] Hardware never writes transfer-allowed setting
// [RULE_16] Config changes only while setting NAK
// [RULE_17] No config change while on FIFO port; this block has no FIFO port, config is gated by NAK only
// [RULE_18] Toggle on each acknowledged data transfer
// [RULE_19] Toggle readable, force strobes for both values
// [RULE_20] Peripheral sets toggle at control stages
// [RULE_21] Software sets toggle around ClearFeature
// [RULE_22] Force-to-DATA1 ignored on isochronous pipes
// [RULE_23] All pipes start at NAK
module usbp_pipe_ctrl (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic evt_valid,
   input wire logic [3:0] evt_code,
   input wire logic [3:0] evt_pipe,
   input wire logic [10:0] evt_len,
   input wire logic [63:0] setup_data,
   input wire logic [9:0] buf_has_data,
   input wire logic [9:0] buf_has_space,
   input wire logic query_valid,
   input wire logic [3:0] query_pipe,
   input wire logic query_in,
   input wire logic query_setup,
   output logic hs_valid,
   output logic [1:0] hs_code,
   output logic token_valid,
   output logic [3:0] token_pipe,
   output logic token_out,
   input wire logic token_taken
);
   localparam int NP = usbp_pkg::NUM_PIPES;
   localparam int MW = usbp_pkg::MPS_W;
   localparam int PW = usbp_pkg::PIPE_W;

   // Buffer status ports are ten wide, so more pipes cannot be served
   if (NP > (1 << PW) || NP < 1 || NP > 10) begin : g_bad_pipes
      $error("Pipe count does not fit the pipe index");
   end

   // ***********************************************
   // State
   // ***********************************************
   typedef struct packed {
      logic [NP-1:0][1:0] pid;
      logic [NP-1:0][1:0] ptype;
      logic [NP-1:0] dir;
      logic [NP-1:0] short_stop;
      logic [NP-1:0][MW-1:0] mps;
      logic [NP-1:0] toggle;
      logic [NP-1:0][1:0] errcnt;
      logic host_mode;
      logic [63:0] req;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic hs_valid;
      logic [1:0] hs_code;
      logic tok_valid;
      logic [PW-1:0] tok_pipe;
      logic tok_out;
   } usbp_state_type;

   usbp_state_type s_q;
   usbp_state_type s_d;

   logic wr_en;
   logic rd_setup;
   logic [PW-1:0] ctrl_idx;
   logic [PW-1:0] cfg_idx;
   logic is_ctrl;
   logic is_cfg;
   logic ev_ok;
   logic [PW-1:0] ep;
   logic found;
   logic [PW-1:0] pick;
   logic pick_out;
   logic [31:0] rd_word;
   logic rd_err;

   assign wr_en = psel && penable && s_q.pready && pwrite && !s_q.pslverr;
   assign rd_setup = psel && !penable;
   assign ctrl_idx = PW'(paddr[7:2]);
   assign cfg_idx = PW'((paddr - usbp_pkg::CFG_BASE) >> 2);
   assign is_ctrl = (paddr < usbp_pkg::CFG_BASE) && (32'(ctrl_idx) < NP) && (paddr[1:0] == 2'h0);
   assign is_cfg = (paddr >= usbp_pkg::CFG_BASE) && (paddr < usbp_pkg::MODE_ADDR)
      && (32'(cfg_idx) < NP) && (paddr[1:0] == 2'h0);
   assign ev_ok = evt_valid && (32'(evt_pipe) < NP);
   assign ep = evt_pipe;

   // ***********************************************
   // Read mux
   // ***********************************************
   always_comb begin
      rd_word = 32'h0000_0000;
      rd_err = 1'b0;
      if (is_ctrl) begin
         rd_word[usbp_pkg::CTRL_PID_LSB +: 2] = s_q.pid[ctrl_idx];
         rd_word[usbp_pkg::CTRL_MON_BIT] = s_q.toggle[ctrl_idx]; // RULE_19
         rd_word[usbp_pkg::CTRL_ACTIVE_BIT] = s_q.tok_valid && (s_q.tok_pipe == ctrl_idx);
      end else if (is_cfg) begin
         rd_word[usbp_pkg::CFG_TYPE_LSB +: 2] = s_q.ptype[cfg_idx];
         rd_word[usbp_pkg::CFG_DIR_BIT] = s_q.dir[cfg_idx];
         rd_word[usbp_pkg::CFG_SHORT_BIT] = s_q.short_stop[cfg_idx];
         rd_word[usbp_pkg::CFG_MPS_LSB +: MW] = s_q.mps[cfg_idx];
      end else if (paddr == usbp_pkg::MODE_ADDR) begin
         rd_word[0] = s_q.host_mode;
      end else if (paddr == usbp_pkg::REQ_LO_ADDR) begin
         rd_word = s_q.req[31:0];
      end else if (paddr == usbp_pkg::REQ_HI_ADDR) begin
         rd_word = s_q.req[63:32];
      end else begin
         rd_err = 1'b1;
      end
   end

   // ***********************************************
   // Host token picker
   // ***********************************************
   always_comb begin
      found = 1'b0;
      pick = '0;
      pick_out = 1'b0;
      for (int i = NP - 1; i >= 0; i--) begin
         // Only transfer-allowed pipes compete; NAK and STALL pipes stay silent
         if (s_q.pid[i] == usbp_pkg::PID_BUF) begin // RULE_05
            if ((s_q.dir[i] && buf_has_data[i]) || (!s_q.dir[i] && buf_has_space[i])) begin // RULE_06
               found = 1'b1;
               pick = PW'(i);
               pick_out = s_q.dir[i];
            end
         end
      end
   end

   // ***********************************************
   // Next state
   // ***********************************************
   always_comb begin
      s_d = s_q;
      s_d.hs_valid = 1'b0;

      // APB: answer one cycle after setup, so pready rises in the access phase
      s_d.pready = rd_setup;
      if (rd_setup) begin
         s_d.prdata = pwrite ? 32'h0000_0000 : rd_word;
         s_d.pslverr = rd_err;
      end else if (!psel) begin
         s_d.pslverr = 1'b0;
      end

      if (wr_en && is_ctrl && pstrb[0]) begin
         s_d.pid[ctrl_idx] = (pwdata[1:0] == 2'h3) ? usbp_pkg::PID_STALL : pwdata[1:0];
         // Toggle strobes are refused while the pipe may transfer
         if (s_q.pid[ctrl_idx] == usbp_pkg::PID_NAK) begin // RULE_16
            if (pwdata[usbp_pkg::CTRL_FORCE0_BIT]) begin
               s_d.toggle[ctrl_idx] = 1'b0; // RULE_19
            end else if (pwdata[usbp_pkg::CTRL_FORCE1_BIT]
                         && s_q.ptype[ctrl_idx] != usbp_pkg::TYPE_ISO) begin // RULE_22
               s_d.toggle[ctrl_idx] = 1'b1; // RULE_19
            end
         end
      end
      // Config is frozen unless the pipe is at NAK
      if (wr_en && is_cfg && s_q.pid[cfg_idx] == usbp_pkg::PID_NAK) begin // RULE_16
         if (pstrb[0]) begin
            s_d.ptype[cfg_idx] = pwdata[usbp_pkg::CFG_TYPE_LSB +: 2];
            s_d.dir[cfg_idx] = pwdata[usbp_pkg::CFG_DIR_BIT];
            s_d.short_stop[cfg_idx] = pwdata[usbp_pkg::CFG_SHORT_BIT];
         end
         if (pstrb[2] && pstrb[3]) begin
            s_d.mps[cfg_idx] = pwdata[usbp_pkg::CFG_MPS_LSB +: MW];
         end
      end
      if (wr_en && paddr == usbp_pkg::MODE_ADDR && pstrb[0]) begin
         s_d.host_mode = pwdata[0];
      end

      // Link events follow software writes so a hardware force wins the same cycle
      if (ev_ok) begin
         case (evt_code) // RULE_15
            usbp_pkg::EV_DATA_ACKED: begin
               s_d.errcnt[ep] = 2'h0;
               if (s_q.ptype[ep] != usbp_pkg::TYPE_ISO) begin
                  s_d.toggle[ep] = !s_q.toggle[ep]; // RULE_18
               end
            end
            usbp_pkg::EV_RX_OK: begin
               s_d.errcnt[ep] = 2'h0;
               if (evt_len > s_q.mps[ep]) begin
                  s_d.pid[ep] = usbp_pkg::PID_STALL; // RULE_12 RULE_14
               end else if (evt_len < s_q.mps[ep] && s_q.short_stop[ep]
                            && (s_q.ptype[ep] == usbp_pkg::TYPE_BULK
                                || (s_q.host_mode && ep == '0 && !s_q.dir[ep]))) begin
                  s_d.pid[ep] = usbp_pkg::PID_NAK; // RULE_11 RULE_13
               end
            end
            usbp_pkg::EV_RX_ERR, usbp_pkg::EV_NO_RESP: begin
               // Missing answers do not count against isochronous pipes
               if (s_q.host_mode && !(evt_code == usbp_pkg::EV_NO_RESP
                                      && s_q.ptype[ep] == usbp_pkg::TYPE_ISO)) begin
                  if (s_q.errcnt[ep] == usbp_pkg::ERR_LIMIT - 2'h1) begin
                     s_d.errcnt[ep] = 2'h0;
                     s_d.pid[ep] = usbp_pkg::PID_NAK; // RULE_10
                  end else begin
                     s_d.errcnt[ep] = s_q.errcnt[ep] + 2'h1;
                  end
               end
            end
            usbp_pkg::EV_STALL_RX: begin
               if (s_q.host_mode) begin
                  s_d.pid[ep] = usbp_pkg::PID_STALL; // RULE_12
               end
            end
            usbp_pkg::EV_TRN_DONE: begin
               if (s_q.short_stop[ep] && s_q.ptype[ep] == usbp_pkg::TYPE_BULK) begin
                  s_d.pid[ep] = usbp_pkg::PID_NAK; // RULE_11 RULE_13
               end
            end
            usbp_pkg::EV_SETUP_OK: begin
               if (!s_q.host_mode && ep == '0) begin
                  s_d.pid[ep] = usbp_pkg::PID_NAK; // RULE_13
                  s_d.toggle[ep] = 1'b0; // RULE_20
               end
            end
            usbp_pkg::EV_SEQ_ERR: begin
               if (!s_q.host_mode) begin
                  s_d.pid[ep] = usbp_pkg::PID_STALL; // RULE_14
               end
            end
            usbp_pkg::EV_STATUS_STAGE: begin
               if (!s_q.host_mode) begin
                  s_d.toggle[ep] = 1'b1; // RULE_20
               end
            end
            default: begin
            end
         endcase
      end
      // No path above ever loads PID_BUF from a link event

      // Peripheral handshake answer
      if (query_valid && !s_q.host_mode && 32'(query_pipe) < NP) begin
         s_d.hs_valid = 1'b1;
         if (query_setup) begin
            s_d.hs_code = usbp_pkg::HS_ACK; // RULE_09
            s_d.req = setup_data; // RULE_09
         end else begin
            case (s_q.pid[query_pipe])
               usbp_pkg::PID_BUF: begin
                  if (query_in) begin
                     s_d.hs_code = buf_has_data[query_pipe] ? usbp_pkg::HS_DATA : usbp_pkg::HS_NAK; // RULE_08
                  end else begin
                     s_d.hs_code = buf_has_space[query_pipe] ? usbp_pkg::HS_ACK : usbp_pkg::HS_NAK; // RULE_08
                  end
               end
               usbp_pkg::PID_NAK: begin
                  s_d.hs_code = usbp_pkg::HS_NAK; // RULE_07
               end
               default: begin
                  s_d.hs_code = usbp_pkg::HS_STALL; // RULE_07
               end
            endcase
         end
      end

      // Host token offer: held until taken, withdrawn if the pipe leaves BUF
      if (!s_q.host_mode) begin
         s_d.tok_valid = 1'b0;
      end else if (s_q.tok_valid) begin
         if (token_taken || s_d.pid[s_q.tok_pipe] != usbp_pkg::PID_BUF) begin // RULE_05
            s_d.tok_valid = 1'b0;
         end
      end else if (found && s_d.pid[pick] == usbp_pkg::PID_BUF) begin
         s_d.tok_valid = 1'b1; // RULE_06
         s_d.tok_pipe = pick;
         s_d.tok_out = pick_out;
      end
   end

   // ***********************************************
   // Registers
   // ***********************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q.pid <= {NP{usbp_pkg::PID_NAK}}; // RULE_23
         s_q.ptype <= {NP{usbp_pkg::TYPE_CTRL}};
         s_q.dir <= '0;
         s_q.short_stop <= '0;
         s_q.mps <= {NP{usbp_pkg::MPS_RESET}};
         s_q.toggle <= '0;
         s_q.errcnt <= '0;
         s_q.host_mode <= usbp_pkg::HOST_MODE_RESET;
         s_q.req <= 64'h0;
         s_q.prdata <= 32'h0000_0000;
         s_q.pready <= 1'b0;
         s_q.pslverr <= 1'b0;
         s_q.hs_valid <= 1'b0;
         s_q.hs_code <= usbp_pkg::HS_NAK;
         s_q.tok_valid <= 1'b0;
         s_q.tok_pipe <= '0;
         s_q.tok_out <= 1'b0;
      end else begin
         s_q <= s_d;
      end
   end

   assign prdata = s_q.prdata;
   assign pready = s_q.pready;
   assign pslverr = s_q.pslverr;
   assign hs_valid = s_q.hs_valid;
   assign hs_code = s_q.hs_code;
   assign token_valid = s_q.tok_valid;
   assign token_pipe = s_q.tok_pipe;
   assign token_out = s_q.tok_out;
endmodule : usbp_pipe_ctrl
`default_nettype wire

// [tb/usbp_pipe_checker.sv]
// Purpose: Port-level assertions for the pipe response block
// Assumes: One clock domain, asynchronous active-low reset
// Notes: Queries are only sent in peripheral mode
`default_nettype none
module usbp_pipe_checker (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic query_valid,
   input wire logic query_setup,
   input wire logic hs_valid,
   input wire logic [1:0] hs_code,
   input wire logic token_valid,
   input wire logic [3:0] token_pipe,
   input wire logic token_out,
   input wire logic token_taken,
   input wire logic [9:0] buf_has_data,
   input wire logic [9:0] buf_has_space
);
   timeunit 1ns;
   timeprecision 1ps;
   // ***********************************************
   // Properties
   // ***********************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_apb_setup;
      psel && !penable;
   endsequence
   sequence s_setup_answer;
      query_valid && query_setup ##1 hs_valid;
   endsequence
   chk_apb_answer: assert property (s_apb_setup |=> pready)
      else $error("no ready after setup");
   chk_ready_pulse: assert property (pready |=> !pready)
      else $error("ready held too long");
   chk_hs_cause: assert property (hs_valid |-> $past(query_valid))
      else $error("answer without query");
   chk_setup_ack: assert property (s_setup_answer |-> hs_code == usbp_pkg::HS_ACK)
      else $error("setup not acknowledged");
   chk_token_drop: assert property (token_valid && token_taken |=> !token_valid)
      else $error("offer kept after take");
   chk_token_steady: assert property (token_valid && $past(token_valid) |-> $stable({token_pipe, token_out}))
      else $error("offer changed while pending");
   // Offer is built from the previous cycle's buffer levels
   chk_out_data: assert property ($rose(token_valid) && token_out |->
      (($past(buf_has_data) >> token_pipe) & 10'h001) != 10'h000)
      else $error("out offered without data");
   chk_in_space: assert property ($rose(token_valid) && !token_out |->
      (($past(buf_has_space) >> token_pipe) & 10'h001) != 10'h000)
      else $error("in offered without space");
endmodule : usbp_pipe_checker
`default_nettype wire

// [tb/usbp_far_model.sv]
// Purpose: Serial engine stand-in driving link events and queries
// Assumes: Bench calls one task at a time
// Notes: Takes token offers after an adjustable delay
`default_nettype none
module usbp_far_model (
   input wire logic pclk,
   input wire logic token_valid,
   output logic evt_valid,
   output logic [3:0] evt_code,
   output logic [3:0] evt_pipe,
   output logic [10:0] evt_len,
   output logic query_valid,
   output logic [3:0] query_pipe,
   output logic query_in,
   output logic query_setup,
   output logic token_taken
);
   timeunit 1ns;
   timeprecision 1ps;
   int take_delay = 2;
   int n_tok;
   int waited;
   initial begin
      {evt_valid, evt_code, evt_pipe, evt_len, query_valid, query_pipe, query_in, query_setup, token_taken} = '0;
   end
   // Idle lines show inverted data so stale values are never trusted
   task automatic ev(input logic [3:0] c, input logic [3:0] p, input logic [10:0] l);
      @(posedge pclk);
      {evt_valid, evt_code, evt_pipe, evt_len} <= {1'b1, c, p, l};
      @(posedge pclk);
      {evt_valid, evt_code, evt_pipe, evt_len} <= {1'b0, ~c, ~p, ~l};
   endtask : ev
   task automatic qry(input logic [3:0] p, input logic i, input logic s);
      @(posedge pclk);
      {query_valid, query_pipe, query_in, query_setup} <= {1'b1, p, i, s};
      @(posedge pclk);
      {query_valid, query_pipe, query_in, query_setup} <= {1'b0, ~p, ~i, ~s};
   endtask : qry
   always @(posedge pclk) begin
      token_taken <= 1'b0;
      if (token_valid && !token_taken) begin
         if (waited >= take_delay) begin
            token_taken <= 1'b1;
            n_tok++;
            waited = 0;
         end else begin
            waited++;
         end
      end
   end
endmodule : usbp_far_model
`default_nettype wire

// [tb/tb.sv]
// Purpose: Self-checking bench for the pipe response block
// Assumes: APB answer latency is not relied on
// Notes: Random values from a fixed xorshift seed
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, hs_valid, token_valid, token_out, token_taken, e;
   logic evt_valid, query_valid, query_in, query_setup;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, seed, q, r;
   logic [3:0] evt_code, evt_pipe, query_pipe, token_pipe;
   logic [10:0] evt_len, m;
   logic [63:0] setup_data;
   logic [9:0] buf_has_data, buf_has_space;
   logic [1:0] hs_code, pid;
   int miscompares, n_checks, cyc, n;
   usbp_pipe_ctrl uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hf), .prdata,
      .pready, .pslverr, .evt_valid, .evt_code, .evt_pipe, .evt_len, .setup_data, .buf_has_data, .buf_has_space,
      .query_valid, .query_pipe, .query_in, .query_setup, .hs_valid, .hs_code, .token_valid, .token_pipe,
      .token_out, .token_taken);
   usbp_far_model far (.pclk, .token_valid, .evt_valid, .evt_code, .evt_pipe, .evt_len, .query_valid,
      .query_pipe, .query_in, .query_setup, .token_taken);
   // ***********************************************
   // Helpers
   // ***********************************************
   function logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   function automatic logic [1:0] exp_hs(logic [1:0] p, logic i, logic hd, logic hsp);
      if (p != usbp_pkg::PID_BUF) return (p == usbp_pkg::PID_NAK) ? usbp_pkg::HS_NAK : usbp_pkg::HS_STALL;
      if (i) return hd ? usbp_pkg::HS_DATA : usbp_pkg::HS_NAK;
      return hsp ? usbp_pkg::HS_ACK : usbp_pkg::HS_NAK;
   endfunction : exp_hs
   task automatic conclude();
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : conclude
   task automatic fail(input logic [31:0] got, input logic [31:0] exp);
      miscompares++;
      $display("[FAIL] %0t: got %h expected %h", $time, got, exp);
   endtask : fail
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) fail(got, exp);
   endtask : cmp
   task automatic cmp_hs(input logic [1:0] exp);
      n_checks++;
      if ({hs_valid, hs_code} !== {1'b1, exp}) fail({hs_valid, hs_code}, {1'b1, exp});
   endtask : cmp_hs
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      // Only the bench timeout ends a wait for ready
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      {psel, penable} <= 2'b00;
   endtask : apb
   task automatic ask(input logic [3:0] p, input logic i, input logic s, input logic [1:0] x);
      far.qry(p, i, s);
      @(posedge pclk);
      cmp_hs(x);
   endtask : ask
   task automatic forced(input logic [3:0] c, input logic [10:0] l, input logic [1:0] x);
      apb(1'b1, 8'h04, 32'h1);
      far.ev(c, 4'h1, l);
      apb(1'b0, 8'h04, '0);
      cmp(q[1:0], x);
   endtask : forced
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         miscompares++;
         conclude();
      end
   end
   // ***********************************************
   // Main sequence
   // ***********************************************
   initial begin
      seed = 32'h7263cc97;
      {presetn, psel, penable, pwrite, paddr, pwdata, setup_data, buf_has_data, buf_has_space} = '0;
      pclk = 1'b0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 10; i++) begin
         apb(1'b0, 8'(i * 4), '0);
         cmp(q[1:0], usbp_pkg::PID_NAK);
      end
      apb(1'b0, 8'h40, '0);
      cmp(q, {5'h0, usbp_pkg::MPS_RESET, 16'h0});
      apb(1'b0, 8'hfc, '0);
      cmp(e, 1'h1);
      $display("reset and map done");
      r = rnd();
      m = r[2] ? 11'h200 : 11'h008 << r[1:0];
      apb(1'b1, 8'h04, 32'h1);
      apb(1'b1, 8'h44, {5'h0, m, 16'hd});
      apb(1'b0, 8'h44, '0);
      cmp(q, {5'h0, usbp_pkg::MPS_RESET, 16'h0});
      apb(1'b1, 8'h04, '0);
      apb(1'b1, 8'h44, {5'h0, m, 16'hd});
      apb(1'b0, 8'h44, '0);
      cmp(q, {5'h0, m, 16'hd});
      apb(1'b1, 8'h58, {5'h0, 11'h020, 16'h1});
      apb(1'b0, 8'h58, '0);
      cmp(q, {5'h0, 11'h020, 16'h1});
      $display("config lock done");
      apb(1'b1, 8'h04, 32'h40);
      apb(1'b0, 8'h04, '0);
      cmp(q[7], 1'h1);
      apb(1'b1, 8'h04, 32'h20);
      apb(1'b0, 8'h04, '0);
      cmp(q[7], 1'h0);
      apb(1'b1, 8'h48, {5'h0, 11'h3ff, 16'h3});
      apb(1'b1, 8'h08, 32'h40);
      apb(1'b0, 8'h08, '0);
      cmp(q[7], 1'h0);
      apb(1'b1, 8'h04, 32'h1);
      far.ev(usbp_pkg::EV_DATA_ACKED, 4'h1, '0);
      apb(1'b0, 8'h04, '0);
      cmp(q[7:0] & 8'h83, 8'h81);
      $display("toggle done");
      for (int k = 0; k < 12; k++) begin
         r = rnd();
         pid = (r[21:20] == 2'h3) ? usbp_pkg::PID_BUF : r[21:20];
         buf_has_data <= r[9:0];
         buf_has_space <= r[19:10];
         apb(1'b1, 8'h0c, {30'h0, pid});
         ask(4'h3, r[22], 1'b0, exp_hs(pid, r[22], r[3], r[13]));
      end
      apb(1'b1, 8'h00, 32'h40);
      apb(1'b1, 8'h00, 32'h2);
      setup_data <= {rnd(), rnd()};
      ask(4'h0, 1'b0, 1'b1, usbp_pkg::HS_ACK);
      apb(1'b0, 8'h84, '0);
      cmp(q, setup_data[31:0]);
      apb(1'b0, 8'h88, '0);
      cmp(q, setup_data[63:32]);
      far.ev(usbp_pkg::EV_SETUP_OK, 4'h0, '0);
      apb(1'b0, 8'h00, '0);
      cmp({q[7], q[1:0]}, 3'h0);
      far.ev(usbp_pkg::EV_STATUS_STAGE, 4'h0, '0);
      apb(1'b0, 8'h00, '0);
      cmp(q[7], 1'h1);
      $display("peripheral answers done");
      forced(usbp_pkg::EV_RX_OK, m + 11'h1, usbp_pkg::PID_STALL);
      forced(usbp_pkg::EV_RX_OK, m - 11'h1, usbp_pkg::PID_NAK);
      forced(usbp_pkg::EV_TRN_DONE, '0, usbp_pkg::PID_NAK);
      forced(usbp_pkg::EV_SEQ_ERR, '0, usbp_pkg::PID_STALL);
      $display("peripheral forcing done");
      buf_has_data <= '0;
      buf_has_space <= '0;
      apb(1'b1, 8'h0c, '0);
      apb(1'b1, 8'h80, 32'h1);
      apb(1'b1, 8'h04, 32'h1);
      for (int k = 0; k < 3; k++) begin
         far.ev((k == 1) ? usbp_pkg::EV_NO_RESP : usbp_pkg::EV_RX_ERR, 4'h1, '0);
         apb(1'b0, 8'h04, '0);
         cmp(q[1:0], (k == 2) ? usbp_pkg::PID_NAK : usbp_pkg::PID_BUF);
      end
      forced(usbp_pkg::EV_STALL_RX, '0, usbp_pkg::PID_STALL);
      forced(usbp_pkg::EV_RX_OK, m + 11'h1, usbp_pkg::PID_STALL);
      forced(usbp_pkg::EV_TRN_DONE, '0, usbp_pkg::PID_NAK);
      buf_has_data <= 10'h002;
      buf_has_space <= 10'h010;
      n = far.n_tok;
      apb(1'b1, 8'h04, 32'h1);
      apb(1'b1, 8'h10, 32'h1);
      repeat (30) @(posedge pclk);
      cmp(far.n_tok > n + 1, 1'h1);
      apb(1'b1, 8'h04, '0);
      apb(1'b1, 8'h10, 32'h2);
      repeat (5) @(posedge pclk);
      n = far.n_tok;
      repeat (30) @(posedge pclk);
      cmp(far.n_tok, n);
      $display("host tokens done");
      conclude();
   end
   initial begin
      forever #2.5 pclk = ~pclk;
   end
endmodule : tb
bind usbp_pipe_ctrl usbp_pipe_checker chk (.pclk, .presetn, .psel, .penable, .pready, .query_valid, .query_setup,
   .hs_valid, .hs_code, .token_valid, .token_pipe, .token_out, .token_taken, .buf_has_data, .buf_has_space);
`default_nettype wire
